// ---- core/event_routine_binding_irq.sv ----
// interrupt event to routine binding, queueing and dispatch
`timescale 1ns/1ps
`default_nettype none
module event_routine_binding_irq
    import irq_bind_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // operations from the processor core
    input wire logic op_valid_i,
    input wire op_t op_code_i,
    input wire logic [EV_W-1:0] op_event_i,
    input wire logic [RT_W-1:0] op_routine_i,
    // configuration and mode
    input wire logic [1:0] variant_i,
    input wire logic run_entry_i,
    // digital input pins (asynchronous)
    input wire logic [NUM_PIN-1:0] din_i,
    // fast counter sources
    input wire logic [5:0] fc_match_i,
    input wire logic [3:0] fc_dir_i,
    input wire logic [3:0] fc_ext_reset_i,
    input wire logic [5:0] fc_conflict_i,
    // serial, timed, timer and pulse sources
    input wire logic [1:0] rx_char_i,
    input wire logic [1:0] tx_done_i,
    input wire logic [1:0] rx_msg_i,
    input wire logic [1:0] timed_i,
    input wire logic [1:0] timer_match_i,
    input wire logic [1:0] pulse_done_i,
    // operation result
    output logic op_done_o,
    output logic enable_out_o,
    output logic [ERR_W-1:0] error_code_o,
    // dispatch to the core
    output logic dispatch_valid_o,
    output logic [EV_W-1:0] dispatch_event_o,
    output logic [RT_W-1:0] dispatch_routine_o,
    // status
    output logic global_enable_o,
    output logic overflow_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NUM_EV-1:0] bound;                  // valid bit per entry
        logic [NUM_EV-1:0][RT_W-1:0] routine;      // bound routine per entry
        logic [NUM_EV-1:0] pending;                // one queued occurrence per event
        logic gie;                                 // global enable
        logic [NUM_PIN-1:0] sync1;                 // first sync stage
        logic [NUM_PIN-1:0] sync2;                 // second sync stage
        logic [NUM_PIN-1:0] pin_prev;              // previous synced level
        logic op_done;
        logic enable_out;
        logic [ERR_W-1:0] error_code;
        logic disp_valid;
        logic [EV_W-1:0] disp_event;
        logic [RT_W-1:0] disp_routine;
        logic overflow;
    } state_t;

    state_t st;                      // registered state
    state_t next_st;                 // next state
    logic [NUM_EV-1:0] raw;          // events raised this cycle
    logic sel_valid;                 // a pending event is chosen for dispatch
    logic [EV_W-1:0] sel_ev;         // the chosen event

    // ****************************************
    // decoding helpers
    // ****************************************
    // event number legal for the product variant
    function automatic logic ev_ok(input logic [EV_W-1:0] ev, input logic [1:0] variant);
        logic hi;
        hi = (ev >= EV_HIGH_BASE) && (ev <= EV_LAST);
        if (variant == VARIANT_SMALL) begin
            ev_ok = (ev <= EV_SMALL_LO_END) || ((ev >= EV_MID_BASE) && (ev <= EV_MID_END)) || hi;
        end else if (variant == VARIANT_MID) begin
            ev_ok = (ev <= EV_MID_END) || hi;
        end else begin
            ev_ok = (ev <= EV_LAST);
        end
    endfunction

    // event belongs to a counter whose input assignment conflicts
    function automatic logic fc_conflicts(input logic [EV_W-1:0] ev, input logic [5:0] cf);
        fc_conflicts = 1'b0;
        for (int c = 0; c < 6; c++) begin
            if (ev == EV_FC_MATCH[c] && cf[c]) begin
                fc_conflicts = 1'b1;
            end
        end
        for (int k = 0; k < 4; k++) begin
            if ((ev == EV_FC_DIR[k] || ev == EV_FC_RST[k]) && cf[FC_AUX_CTR[k]]) begin
                fc_conflicts = 1'b1;
            end
        end
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic found;
        found = 1'b0;
        next_st = st;
        sel_valid = 1'b0;
        sel_ev = '0;
        // pins pass two flops before edge detection
        next_st.sync1 = din_i;
        next_st.sync2 = st.sync1;
        next_st.pin_prev = st.sync2;
        next_st.op_done = 1'b0;
        next_st.disp_valid = 1'b0;
        next_st.overflow = 1'b0;
        raw = '0;
        // rising edge even, falling edge odd
        for (int p = 0; p < NUM_PIN; p++) begin
            raw[2*p] = st.sync2[p] & ~st.pin_prev[p];
            raw[2*p+1] = ~st.sync2[p] & st.pin_prev[p];
        end
        for (int c = 0; c < 6; c++) begin
            raw[EV_FC_MATCH[c]] = fc_match_i[c];
        end
        for (int k = 0; k < 4; k++) begin
            raw[EV_FC_DIR[k]] = fc_dir_i[k];
            raw[EV_FC_RST[k]] = fc_ext_reset_i[k];
        end
        for (int q = 0; q < 2; q++) begin
            raw[EV_RX_CHAR[q]] = rx_char_i[q];
            raw[EV_TX_DONE[q]] = tx_done_i[q];
            raw[EV_RX_MSG[q]] = rx_msg_i[q];
            raw[EV_TIMED[q]] = timed_i[q];
            raw[EV_TMR_MATCH[q]] = timer_match_i[q];
            raw[EV_PULSE_DONE[q]] = pulse_done_i[q];
        end
        // events the variant lacks are never raised
        for (int e = 0; e < NUM_EV; e++) begin
            raw[e] = raw[e] & ev_ok(EV_W'(e), variant_i);
        end
        // queue only bound events; a repeat while queued is an overflow
        for (int e = 0; e < NUM_EV; e++) begin
            if (raw[e] && st.bound[e]) begin
                if (st.pending[e]) begin
                    next_st.overflow = 1'b1;
                end
                next_st.pending[e] = 1'b1;
            end
        end
        // lowest pending event goes first while globally enabled
        if (st.gie) begin
            for (int e = 0; e < NUM_EV; e++) begin
                if (!found && st.pending[e]) begin
                    found = 1'b1;
                    sel_ev = EV_W'(e);
                    // a new occurrence in the same cycle stays queued
                    next_st.pending[e] = raw[e] & st.bound[e];
                    if (st.bound[e]) begin
                        sel_valid = 1'b1;
                        next_st.disp_valid = 1'b1;
                        next_st.disp_event = EV_W'(e);
                        next_st.disp_routine = st.routine[e];
                    end
                end
            end
        end
        // operations from the core
        if (op_valid_i) begin
            next_st.op_done = 1'b1;
            next_st.enable_out = 1'b1;
            next_st.error_code = ERR_NONE;
            case (op_code_i)
                OP_ATTACH: begin
                    if (!ev_ok(op_event_i, variant_i)) begin
                        next_st.enable_out = 1'b0;
                        next_st.error_code = ERR_RANGE;
                    end else if (fc_conflicts(op_event_i, fc_conflict_i)) begin
                        next_st.enable_out = 1'b0;
                        next_st.error_code = ERR_CONFLICT;
                    end else begin
                        // one entry per event: the new routine replaces the old
                        next_st.bound[op_event_i] = 1'b1;
                        next_st.routine[op_event_i] = op_routine_i;
                    end
                end
                OP_DETACH: begin
                    if (!ev_ok(op_event_i, variant_i)) begin
                        next_st.enable_out = 1'b0;
                        next_st.error_code = ERR_RANGE;
                    end else begin
                        next_st.bound[op_event_i] = 1'b0;
                        next_st.pending[op_event_i] = 1'b0;
                    end
                end
                OP_ENABLE: begin
                    next_st.gie = 1'b1;
                end
                default: begin
                    next_st.gie = 1'b0;
                end
            endcase
        end
        // run entry overrides any enable in the same cycle
        if (run_entry_i) begin
            next_st.gie = GIE_RESET;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs, all straight from flops
    // ****************************************
    assign op_done_o = st.op_done;
    assign enable_out_o = st.enable_out;
    assign error_code_o = st.error_code;
    assign dispatch_valid_o = st.disp_valid;
    assign dispatch_event_o = st.disp_event;
    assign dispatch_routine_o = st.disp_routine;
    assign global_enable_o = st.gie;
    assign overflow_o = st.overflow;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_attach_ok;
        op_valid_i && op_code_i == OP_ATTACH && ev_ok(op_event_i, variant_i)
            && !fc_conflicts(op_event_i, fc_conflict_i);
    endsequence
    sequence s_pin0_rise_held;
        !din_i[0] ##1 (din_i[0] && st.bound[0] && !st.gie && !op_valid_i) [*3];
    endsequence

    property p_attach;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_attach_ok |=> st.bound[$past(op_event_i)]
            && st.routine[$past(op_event_i)] == $past(op_routine_i) && enable_out_o;
    endproperty
    a_attach: assert property (p_attach) else $error("attach not recorded");
    property p_detach;
        @(posedge clock_i) disable iff (!rst_b_i)
        op_valid_i && op_code_i == OP_DETACH && ev_ok(op_event_i, variant_i)
            |=> !st.bound[$past(op_event_i)] && !st.pending[$past(op_event_i)];
    endproperty
    a_detach: assert property (p_detach) else $error("detach left binding");
    property p_routine;
        @(posedge clock_i) disable iff (!rst_b_i)
        sel_valid |=> dispatch_valid_o && dispatch_routine_o == $past(st.routine[sel_ev]);
    endproperty
    a_routine: assert property (p_routine) else $error("wrong routine dispatched");
    property p_queue_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        !st.gie |=> !dispatch_valid_o;
    endproperty
    a_queue_hold: assert property (p_queue_hold) else $error("dispatch while disabled");
    property p_bound_only;
        @(posedge clock_i) disable iff (!rst_b_i)
        dispatch_valid_o |-> $past(st.bound[sel_ev] && st.pending[sel_ev] && st.gie);
    endproperty
    a_bound_only: assert property (p_bound_only) else $error("unbound dispatch");
    property p_conflict;
        @(posedge clock_i) disable iff (!rst_b_i)
        op_valid_i && op_code_i == OP_ATTACH && ev_ok(op_event_i, variant_i)
            && fc_conflicts(op_event_i, fc_conflict_i)
            |=> op_done_o && !enable_out_o && error_code_o == ERR_CONFLICT;
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not reported");

    property p_range;
        @(posedge clock_i) disable iff (!rst_b_i)
        op_valid_i && op_code_i == OP_ATTACH && !ev_ok(op_event_i, variant_i)
            |=> !enable_out_o && $stable(st.bound);
    endproperty
    a_range: assert property (p_range) else $error("illegal event attached");

    property p_run_entry;
        @(posedge clock_i) disable iff (!rst_b_i)
        run_entry_i |=> !global_enable_o ##1 !dispatch_valid_o;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("enable after run entry");

    property p_pin_edge;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_pin0_rise_held |=> st.pending[0];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("rising edge not queued");
endmodule
`default_nettype wire

// ---- inc/irq_bind_pkg.sv ----
// constants and types for the interrupt event binding block
// Behaviour
// - attach binds routine to event, sets enable
// - detach clears binding and event enable
// - event dispatches only to latest attached routine
// - many events may share one routine
// - global disable queues bound events until enable
// - unbound or detached events never dispatched nor queued
// - counter input conflict on attach reports 0002
// - valid event range depends on product variant
// - counter match events 12,13,16,32,29,33
// - pulse channel done raises events 19, 20
// - run entry clears global enable
// - input edges: rising even, falling next odd
`default_nettype none
package irq_bind_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_EV = 34;        // events 0..33
    localparam int EV_W = 6;           // event number width
    localparam int RT_W = 7;           // routine number width, 0..127
    localparam int NUM_PIN = 4;        // edge-sensing inputs
    localparam int ERR_W = 16;         // error code width

    // ****************************************
    // operations, variants, error codes
    // ****************************************
    typedef enum logic [1:0] {
        OP_ATTACH,                     // attach_event_op
        OP_DETACH,                     // detach_event_op
        OP_ENABLE,                     // global_irq_enable_op
        OP_DISABLE                     // global_irq_disable_op
    } op_t;
    localparam logic [1:0] VARIANT_SMALL = 2'h0;
    localparam logic [1:0] VARIANT_MID = 2'h1;
    localparam logic [ERR_W-1:0] ERR_NONE = 16'h0000;
    localparam logic [ERR_W-1:0] ERR_CONFLICT = 16'h0002;
    localparam logic [ERR_W-1:0] ERR_RANGE = 16'h0003;
    localparam logic GIE_RESET = 1'b0;

    // ****************************************
    // valid event ranges
    // ****************************************
    localparam logic [EV_W-1:0] EV_SMALL_LO_END = 6'h0c;  // 0..12
    localparam logic [EV_W-1:0] EV_MID_BASE = 6'h13;      // 19
    localparam logic [EV_W-1:0] EV_MID_END = 6'h17;       // 23
    localparam logic [EV_W-1:0] EV_HIGH_BASE = 6'h1b;     // 27
    localparam logic [EV_W-1:0] EV_LAST = 6'h21;          // 33

    // ****************************************
    // event numbers per source
    // ****************************************
    // current-equals-preset, indexed by counter 0..5
    localparam logic [EV_W-1:0] EV_FC_MATCH [6] = '{6'h0c, 6'h0d, 6'h10, 6'h20, 6'h1d, 6'h21};
    // direction change / external reset, counters 0,1,2,4
    localparam logic [EV_W-1:0] EV_FC_DIR [4] = '{6'h1b, 6'h0e, 6'h11, 6'h1e};
    localparam logic [EV_W-1:0] EV_FC_RST [4] = '{6'h1c, 6'h0f, 6'h12, 6'h1f};
    localparam int FC_AUX_CTR [4] = '{0, 1, 2, 4};
    // port 0 / port 1
    localparam logic [EV_W-1:0] EV_RX_CHAR [2] = '{6'h08, 6'h19};
    localparam logic [EV_W-1:0] EV_TX_DONE [2] = '{6'h09, 6'h1a};
    localparam logic [EV_W-1:0] EV_RX_MSG [2] = '{6'h17, 6'h18};
    localparam logic [EV_W-1:0] EV_TIMED [2] = '{6'h0a, 6'h0b};
    localparam logic [EV_W-1:0] EV_TMR_MATCH [2] = '{6'h15, 6'h16};
    localparam logic [EV_W-1:0] EV_PULSE_DONE [2] = '{6'h13, 6'h14};

endpackage
`default_nettype wire

// ---- testbench/core_model.sv ----
// processor core model: issues binding operations and takes dispatches
`timescale 1ns/1ps
`default_nettype none
module core_model
    import irq_bind_pkg::*;
(
    // clock
    input wire logic clock_i,
    // operation request
    output logic op_valid_o,
    output op_t op_code_o,
    output logic [EV_W-1:0] op_event_o,
    output logic [RT_W-1:0] op_routine_o,
    output logic run_entry_o,
    // dispatch side of the block
    input wire logic dispatch_valid_i,
    input wire logic [EV_W-1:0] dispatch_event_i,
    input wire logic [RT_W-1:0] dispatch_routine_i,
    input wire logic overflow_i
);
    // ****************************************
    // state
    // ****************************************
    logic [12:0] disp_q [$]; // taken dispatches, event in upper bits
    int n_ovf; // overflow pulses seen

    // quiet request at time zero
    initial begin
        op_valid_o = 1'b0;
        op_code_o = OP_DISABLE;
        op_event_o = 6'h3f;
        op_routine_o = 7'h7f;
        run_entry_o = 1'b0;
        n_ovf = 0;
    end

    // no handshake: every dispatch pulse is taken in its own cycle
    always @(posedge clock_i) begin
        if (dispatch_valid_i === 1'b1) begin
            disp_q.push_back({dispatch_event_i, dispatch_routine_i});
        end
        if (overflow_i === 1'b1) begin
            n_ovf++;
        end
    end

    // one operation held for one edge; operands scrambled afterwards
    task automatic issue(input op_t code, input logic [EV_W-1:0] ev,
        input logic [RT_W-1:0] rt, input logic run);
        @(posedge clock_i);
        #10;
        op_valid_o = 1'b1;
        op_code_o = code;
        op_event_o = ev;
        op_routine_o = rt;
        run_entry_o = run;
        @(posedge clock_i);
        #10;
        op_valid_o = 1'b0;
        run_entry_o = 1'b0;
        op_event_o = ~ev;
        op_routine_o = ~rt;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_event_routine_binding_irq.sv ----
// self-checking bench for the event binding block
`timescale 1ns/1ps
`default_nettype none
module tb_event_routine_binding_irq;
    import irq_bind_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic clock_i, rst_b_i;
    logic [1:0] variant;
    logic [3:0] din;
    logic [25:0] src; // all one-cycle sources, sliced per port
    logic [5:0] conflict;
    logic op_valid, run_entry, op_done, enable_out, disp_valid, gie, ovf;
    op_t op_code;
    logic [EV_W-1:0] op_event, disp_event;
    logic [RT_W-1:0] op_routine, disp_routine;
    logic [ERR_W-1:0] error_code;
    int n_mismatch, total_checks;
    // event raised by each bit of src
    localparam logic [5:0] SRC_EV [26] = '{6'h0a, 6'h0b, 6'h09, 6'h1a, 6'h17, 6'h18,
        6'h13, 6'h14, 6'h08, 6'h19, 6'h15, 6'h16, 6'h0c, 6'h0d, 6'h10, 6'h20, 6'h1d,
        6'h21, 6'h1b, 6'h0e, 6'h11, 6'h1e, 6'h1c, 6'h0f, 6'h12, 6'h1f};
    // range cases: variant, event, accepted
    localparam logic [8:0] RANGE [14] = '{{2'h0, 6'h0c, 1'b1}, {2'h0, 6'h0d, 1'b0},
        {2'h0, 6'h12, 1'b0}, {2'h0, 6'h13, 1'b1}, {2'h0, 6'h17, 1'b1},
        {2'h0, 6'h18, 1'b0}, {2'h0, 6'h1a, 1'b0}, {2'h0, 6'h1b, 1'b1},
        {2'h0, 6'h21, 1'b1}, {2'h1, 6'h17, 1'b1}, {2'h1, 6'h1a, 1'b0},
        {2'h1, 6'h1b, 1'b1}, {2'h2, 6'h18, 1'b1}, {2'h3, 6'h22, 1'b0}};

    event_routine_binding_irq u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .op_valid_i(op_valid), .op_code_i(op_code), .op_event_i(op_event),
        .op_routine_i(op_routine), .variant_i(variant), .run_entry_i(run_entry),
        .din_i(din), .fc_match_i(src[17:12]), .fc_dir_i(src[21:18]),
        .fc_ext_reset_i(src[25:22]), .fc_conflict_i(conflict), .rx_char_i(src[9:8]),
        .tx_done_i(src[3:2]), .rx_msg_i(src[5:4]), .timed_i(src[1:0]),
        .timer_match_i(src[11:10]), .pulse_done_i(src[7:6]), .op_done_o(op_done),
        .enable_out_o(enable_out), .error_code_o(error_code),
        .dispatch_valid_o(disp_valid), .dispatch_event_o(disp_event),
        .dispatch_routine_o(disp_routine), .global_enable_o(gie), .overflow_o(ovf));

    core_model u_core (.clock_i(clock_i), .op_valid_o(op_valid), .op_code_o(op_code),
        .op_event_o(op_event), .op_routine_o(op_routine), .run_entry_o(run_entry),
        .dispatch_valid_i(disp_valid), .dispatch_event_i(disp_event),
        .dispatch_routine_i(disp_routine), .overflow_i(ovf));

    // 10 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one operation and its answer one edge later
    task automatic op(input op_t c, input logic [5:0] e, input logic [6:0] r,
        input logic ok, input logic [15:0] err);
        u_core.issue(c, e, r, 1'b0);
        check("op_done", op_done, 1'b1);
        check("enable_out", enable_out, ok);
        check("error_code", error_code, err);
    endtask

    // bounded wait for one dispatch, then compare it
    task automatic expect_disp(input logic [5:0] e, input logic [6:0] r);
        logic [12:0] d;
        for (int i = 0; i < 8 && u_core.disp_q.size() == 0; i++) begin
            @(posedge clock_i);
            #10;
        end
        if (u_core.disp_q.size() == 0) begin
            check("dispatch wait", 16'h0000, 16'h0001);
            stop_test();
        end else begin
            d = u_core.disp_q.pop_front();
            check("dispatch_event", d[12:7], e);
            check("dispatch_routine", d[6:0], r);
        end
    endtask

    task automatic expect_none(input int n);
        repeat (n) @(posedge clock_i);
        #10;
        check("no dispatch", 16'(u_core.disp_q.size()), 16'h0000);
    endtask

    task automatic pulse(input logic [25:0] bits);
        @(posedge clock_i);
        #10;
        src = bits;
        @(posedge clock_i);
        #10;
        src = '0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check("gie", gie, GIE_RESET);
        check("flags", {12'h000, op_done, enable_out, disp_valid, ovf}, 16'h0000);
        check("error_code", error_code, 16'h0000);
        check("dispatch", {3'h0, disp_event, disp_routine}, 16'h0000);
        $display("test reset done");
    endtask

    // run entry beats a same-cycle enable
    task automatic t_run();
        u_core.issue(OP_ENABLE, 6'h00, 7'h00, 1'b1);
        check("gie run", gie, 1'b0);
        op(OP_ENABLE, 6'h00, 7'h00, 1'b1, ERR_NONE);
        check("gie on", gie, 1'b1);
        $display("test run done");
    endtask

    // every source bit, bound to a routine of its own
    task automatic t_table();
        variant = 2'h2;
        for (int b = 0; b < 26; b++) begin
            op(OP_ATTACH, SRC_EV[b], 7'(b), 1'b1, ERR_NONE);
            pulse(26'h1 << b);
            expect_disp(SRC_EV[b], 7'(b));
        end
        $display("test table done");
    endtask

    // rise then fall on each pin
    task automatic t_pins();
        for (int p = 0; p < 4; p++) begin
            op(OP_ATTACH, 6'(2 * p), 7'h40, 1'b1, ERR_NONE);
            op(OP_ATTACH, 6'(2 * p + 1), 7'h41, 1'b1, ERR_NONE);
            din[p] = 1'b1;
            expect_disp(6'(2 * p), 7'h40);
            din[p] = 1'b0;
            expect_disp(6'(2 * p + 1), 7'h41);
        end
        $display("test pins done");
    endtask

    // re-attach replaces the routine, top routine number
    task automatic t_rebind();
        op(OP_ATTACH, 6'h0a, 7'h7f, 1'b1, ERR_NONE);
        pulse(26'h1);
        expect_disp(6'h0a, 7'h7f);
        expect_none(4);
        $display("test rebind done");
    endtask

    // two events on one routine in the same cycle
    task automatic t_shared();
        op(OP_ATTACH, 6'h09, 7'h05, 1'b1, ERR_NONE);
        op(OP_ATTACH, 6'h17, 7'h05, 1'b1, ERR_NONE);
        pulse(26'h14);
        expect_disp(6'h09, 7'h05);
        expect_disp(6'h17, 7'h05);
        $display("test shared done");
    endtask

    // queued while disabled, second occurrence overflows
    task automatic t_queue();
        op(OP_DISABLE, 6'h00, 7'h00, 1'b1, ERR_NONE);
        check("gie off", gie, 1'b0);
        // a pin edge while disabled is queued as well
        din[0] = 1'b1;
        pulse(26'h40);
        pulse(26'h40);
        expect_none(4);
        check("overflow", 16'(u_core.n_ovf), 16'h0001);
        op(OP_ENABLE, 6'h00, 7'h00, 1'b1, ERR_NONE);
        expect_disp(6'h00, 7'h40);
        expect_disp(6'h13, 7'h06);
        expect_none(4);
        din[0] = 1'b0;
        expect_disp(6'h01, 7'h41);
        $display("test queue done");
    endtask

    // detach drops a queued occurrence and later ones
    task automatic t_detach();
        op(OP_DISABLE, 6'h00, 7'h00, 1'b1, ERR_NONE);
        pulse(26'h80);
        op(OP_DETACH, 6'h14, 7'h00, 1'b1, ERR_NONE);
        op(OP_ENABLE, 6'h00, 7'h00, 1'b1, ERR_NONE);
        pulse(26'h80);
        expect_none(5);
        $display("test detach done");
    endtask

    // conflicting counter inputs refuse the attach
    task automatic t_conflict();
        op(OP_DETACH, 6'h20, 7'h00, 1'b1, ERR_NONE);
        conflict = 6'h08;
        op(OP_ATTACH, 6'h20, 7'h02, 1'b0, ERR_CONFLICT);
        pulse(26'h8000);
        expect_none(5);
        // direction event of counter 4 refused on its conflict
        conflict = 6'h10;
        op(OP_ATTACH, 6'h1e, 7'h03, 1'b0, ERR_CONFLICT);
        conflict = 6'h00;
        $display("test conflict done");
    endtask

    // boundaries of each variant
    task automatic t_range();
        for (int i = 0; i < 14; i++) begin
            variant = RANGE[i][8:7];
            op(OP_ATTACH, RANGE[i][6:1], 7'h00, RANGE[i][0],
                RANGE[i][0] ? ERR_NONE : ERR_RANGE);
        end
        op(OP_DETACH, 6'h22, 7'h00, 1'b0, ERR_RANGE);
        $display("test range done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        rst_b_i = 1'b0;
        variant = 2'h2;
        din = 4'h0;
        src = '0;
        conflict = 6'h00;
        repeat (4) @(posedge clock_i);
        #10;
        rst_b_i = 1'b1;
        t_reset();
        t_run();
        t_table();
        t_pins();
        t_rebind();
        t_shared();
        t_queue();
        t_detach();
        t_conflict();
        t_range();
        stop_test();
    end
endmodule
`default_nettype wire
